// ===== bench/dcs_dma_model.sv
// packet dma controller model that takes scheduling credits
module dcs_dma_model (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic hold,
    output logic credit_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // ready is registered, so a hold lands one cycle late
    // take credits, stall at random
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            credit_ready <= 1'h0;
        else
            credit_ready <= !hold && ($urandom_range(3) != 0);
    end
endmodule

// ===== bench/tb_dma_credit_scheduler.sv
// self-checking bench for the table-driven credit scheduler
`include "dcs_map.svh"
module tb_dma_credit_scheduler;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic hold = 1'h1; // keeps the model from taking unplanned credits
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, d;
    logic pready, pslverr, err, credit_valid, credit_ready, credit_rx;
    logic [3:0] credit_channel, credit_fifo;
    logic [63:0] head = 64'h0; // head channel of each rx fifo
    logic [7:0] tbl [256]; // shadow of the schedule table
    logic [8:0] q [$]; // expected credits, oldest first
    int error_cnt = 0;
    int n_compared = 0;
    int cyc = 0;
    int lens[3] = '{0, 6, 255};
    int laps[3] = '{3, 2, 1};

    dcs_scheduler i_dut (
        .clk(clk),
        .arst_n(arst_n),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .credit_valid(credit_valid),
        .credit_ready(credit_ready),
        .credit_rx(credit_rx),
        .credit_channel(credit_channel),
        .credit_fifo(credit_fifo),
        .rx_head_channel(head)
    );

    dcs_dma_model i_dma (
        .clk(clk),
        .arst_n(arst_n),
        .hold(hold),
        .credit_ready(credit_ready)
    );

    // 40 mhz clock
    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // one compare, counted
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("mismatch %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    // apb transfer; data taken at the edge that sees pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1)
            @(posedge clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // note whole laps of credits; rx takes the fifo head channel
    task note(input int last, input int n);
        logic [7:0] b;
        for (int i = 0; i < n * (last + 1); i++)
        begin
            b = tbl[i % (last + 1)];
            q.push_back({b[7], b[7] ? head[b[3:0]*4 +: 4] : b[3:0], b[3:0]});
        end
    endtask

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // scoreboard: each accepted credit against the oldest note
    // it alone drives hold, so the model stops once the plan runs dry
    always @(posedge clk)
    begin
        if (arst_n && credit_valid && credit_ready)
        begin
            if (q.size() == 0)
                chk("spare credit", 32'h1, 32'h0);
            else
                chk("credit", {credit_rx, credit_channel, credit_fifo},
                    q.pop_front());
        end
        hold <= (q.size() == 0);
    end

    // hang guard, far above the 1300 or so cycles needed
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            tally_and_finish;
        end
    end

    initial
    begin
        void'($urandom(32'h807dd017));
        repeat (16) @(posedge clk);
        arst_n <= 1'h1;
        apb(1'h0, `DCS_OFS_LAST, 32'h0);
        chk("last rst", rd, 32'h0);
        chk("no error", err, 32'h0);
        apb(1'h0, `DCS_OFS_ENABLE, 32'h0);
        chk("enable rst", rd, 32'h0);
        apb(1'h0, 12'h008, 32'h0);
        chk("unmapped", err, 32'h1);
        apb(1'h1, `DCS_OFS_LAST, 32'hffffffff);
        apb(1'h0, `DCS_OFS_LAST, 32'h0);
        chk("last field", rd, 32'hff);
        apb(1'h1, `DCS_OFS_ENABLE, 32'h7fff);
        apb(1'h0, `DCS_OFS_ENABLE, 32'h0);
        chk("enable field", rd, 32'h0);
        for (int k = 0; k < 128; k++)
        begin
            d = $urandom;
            tbl[2*k] = d[7:0];
            tbl[2*k+1] = d[15:8];
            apb(1'h1, `DCS_OFS_TABLE + 12'(4*k), d);
        end
        // one entry, seven entries, then the full table
        for (int i = 0; i < 3; i++)
        begin
            head <= {$urandom, $urandom};
            apb(1'h1, `DCS_OFS_LAST, 32'(lens[i]));
            note(lens[i], laps[i]);
            apb(1'h1, `DCS_OFS_ENABLE, 32'h8000);
            if (i == 2)
            begin
                // stop mid-walk with the consumer willing
                while (q.size() > 200)
                    @(posedge clk);
                apb(1'h1, `DCS_OFS_ENABLE, 32'h0);
                repeat (3)
                begin
                    @(posedge clk);
                    chk("stopped", credit_valid, 32'h0);
                end
                apb(1'h1, `DCS_OFS_ENABLE, 32'h8000);
            end
            while (q.size() != 0)
                @(posedge clk);
            apb(1'h1, `DCS_OFS_ENABLE, 32'h0);
        end
        repeat (4) @(posedge clk);
        tally_and_finish;
    end
endmodule

// ===== design/dcs_scheduler.sv
// table-driven credit scheduler with apb register access
//
// Our own choices: the address map and the APB slave port.
`include "dcs_map.svh"
module dcs_scheduler #(
    parameter int WORDS = `DCS_TABLE_WORDS,
    parameter int FIFOS = 16
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic credit_valid,
    input wire logic credit_ready,
    output logic credit_rx,
    output logic [3:0] credit_channel,
    output logic [3:0] credit_fifo,
    input wire logic [FIFOS*4-1:0] rx_head_channel
);
    localparam int SW = $clog2(WORDS*4);
    localparam int HWB = $clog2(WORDS*2);

    // control registers
    logic [7:0] last_r;
    logic enable_r;
    // walk pointer and state
    logic [SW-1:0] slot_r;
    logic [SW-1:0] slot_nxt;
    dcs_pkg::dcs_state_t state_r;
    dcs_pkg::dcs_state_t state_nxt;
    // entry seen from the table
    logic [7:0] entry_w;
    // registered credit fields and read data
    logic rx_r;
    logic [3:0] chan_r;
    logic [3:0] fifo_r;
    logic [31:0] prdata_r;
    // high in the answering cycle of an access
    logic ack_r;

    // bus decode; one wait state so that read data comes from a flop
    // the first access cycle of a read loads prdata_r, the second answers
    wire access_w = psel && penable;
    wire done_w = access_w && ack_r;
    // writes land only at the edge that sees pready high
    wire wr_w = done_w && pwrite;
    // read data is captured in the waiting cycle
    wire rd_w = access_w && !ack_r && !pwrite;
    wire hit_last = paddr == `DCS_OFS_LAST;
    wire hit_en = paddr == `DCS_OFS_ENABLE;
    wire [11:0] tab_end = 12'(`DCS_OFS_TABLE + WORDS * 8);
    wire hit_tab = paddr >= `DCS_OFS_TABLE && paddr < tab_end
        && paddr[1:0] == 2'b00;
    wire [11:0] tab_off = paddr - `DCS_OFS_TABLE;
    wire [HWB-1:0] tab_idx = tab_off[HWB+1:2];
    wire mapped_w = hit_last || hit_en || hit_tab;
    // table is write-only; a read of it returns zero without an error
    wire [31:0] rd_mux = hit_last ? {24'h0, last_r}
        : hit_en ? {16'h0, enable_r, 15'h0}
        : 32'h0;
    assign pready = ack_r;
    // error shown only while the answer stands
    assign pslverr = done_w && !mapped_w;

    // control register writes
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            last_r <= `DCS_LAST_RST;
            enable_r <= 1'b0;
        end
        else if (wr_w)
        begin
            if (hit_last)
                last_r <= pwdata[`DCS_LAST_LSB +: `DCS_LAST_W];
            if (hit_en)
                enable_r <= pwdata[`DCS_ENABLE_BIT];
        end
    end

    // wait-state flag: set by the first access cycle, cleared by the answering cycle
    // a master that drops psel early just leaves it low again
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            ack_r <= 1'b0;
        else
            ack_r <= access_w && !ack_r;
    end

    // read data register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            prdata_r <= 32'h0;
        else if (rd_w)
            prdata_r <= rd_mux;
    end
    // data held until the next read; costs one wait state per access
    // but keeps the bus free of a combinational read path
    assign prdata = prdata_r;

    // table storage
    dcs_table #(
        .WORDS(WORDS)
    ) u_table (
        .clk(clk),
        .arst_n(arst_n),
        .wr_en(wr_w && hit_tab),
        .wr_idx(tab_idx),
        .wr_data(pwdata[15:0]),
        .rd_slot(slot_r),
        .rd_entry(entry_w)
    );

    // entry decode
    wire entry_rx = entry_w[`DCS_DIR_BIT];
    wire [3:0] entry_ch = entry_w[`DCS_CHAN_LSB +: `DCS_CHAN_W];
    // head channel of the fifo bound to this entry's channel
    wire [3:0] head_ch = rx_head_channel[entry_ch*4 +: 4];
    wire last_slot = slot_r == SW'(last_r);
    wire accept_w = credit_valid && credit_ready;

    // walk control
    always_comb
    begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        unique case (state_r)
            dcs_pkg::DCS_IDLE:
                if (enable_r)
                    state_nxt = dcs_pkg::DCS_FETCH;
            dcs_pkg::DCS_FETCH:
                state_nxt = enable_r ? dcs_pkg::DCS_OFFER : dcs_pkg::DCS_IDLE;
            dcs_pkg::DCS_OFFER:
                if (accept_w)
                begin
                    slot_nxt = last_slot ? '0 : SW'(slot_r + 1'b1);
                    state_nxt = enable_r ? dcs_pkg::DCS_FETCH
                        : dcs_pkg::DCS_IDLE;
                end
                else if (!enable_r)
                    state_nxt = dcs_pkg::DCS_IDLE;
        endcase
    end

    // state and pointer
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= dcs_pkg::DCS_IDLE;
            slot_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            slot_r <= slot_nxt;
        end
    end

    // credit fields captured at fetch
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rx_r <= 1'b0;
            chan_r <= 4'h0;
            fifo_r <= 4'h0;
        end
        else if (state_r == dcs_pkg::DCS_FETCH)
        begin
            rx_r <= entry_rx;
            // rx credit carries fifo head channel
            chan_r <= entry_rx ? head_ch : entry_ch;
            // rx fifo tied to entry channel
            fifo_r <= entry_ch;
        end
    end

    assign credit_valid = state_r == dcs_pkg::DCS_OFFER && enable_r;
    assign credit_rx = rx_r;
    assign credit_channel = chan_r;
    assign credit_fifo = fifo_r;

    property hold_p;
        @(posedge clk) disable iff (!arst_n)
        credit_valid && !credit_ready && enable_r |=>
            (!enable_r) || (credit_valid && $stable(credit_channel)
            && $stable(credit_rx));
    endproperty
    credit_hold_a: assert property (hold_p)
        else $error("credit changed before acceptance");

    credit_off_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        !enable_r |-> !credit_valid)
        else $error("credit offered while disabled");

    walk_park_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        !enable_r |=> state_r == dcs_pkg::DCS_IDLE)
        else $error("walk kept running while disabled");

    // enable bit taken from the bus
    enable_write_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        wr_w && hit_en |=> enable_r == $past(pwdata[`DCS_ENABLE_BIT]))
        else $error("enable bit not written");

    sequence take_s;
        accept_w && enable_r && !last_slot;
    endsequence
    slot_step_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        take_s |=> slot_r == SW'($past(slot_r) + 1'b1))
        else $error("slot did not step by one");

    slot_wrap_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        accept_w && last_slot |=> slot_r == '0)
        else $error("slot did not wrap after last entry");

    slot_keep_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        !accept_w |=> $stable(slot_r))
        else $error("slot moved without acceptance");

    fetch_gap_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        accept_w |=> !credit_valid)
        else $error("credit offered again without a fetch");

    sequence fetch_s;
        state_r == dcs_pkg::DCS_FETCH && enable_r;
    endsequence
    tx_exact_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        fetch_s ##0 !entry_rx |=> credit_channel == $past(entry_ch)
            && !credit_rx)
        else $error("tx credit channel mismatch");

    rx_head_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        fetch_s ##0 entry_rx |=> credit_channel == $past(head_ch)
            && credit_fifo == $past(entry_ch) && credit_rx)
        else $error("rx credit channel mismatch");

    // offer follows fetch; a disable landing there withdraws it
    offer_soon_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        fetch_s |=> state_r == dcs_pkg::DCS_OFFER
            && credit_valid == enable_r)
        else $error("no credit after fetch");

    last_write_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        wr_w && hit_last |=> last_r == $past(pwdata[7:0]))
        else $error("last entry field not written");

    last_read_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        rd_w && hit_last |=> prdata == {24'h0, $past(last_r)})
        else $error("last entry field not read back");

    upper_byte_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        state_r == dcs_pkg::DCS_OFFER && slot_r[0] |->
            entry_w == u_table.mem_r[slot_r[SW-1:1]][15:8])
        else $error("odd slot not from upper byte");

    lower_byte_a: assert property (
        @(posedge clk) disable iff (!arst_n)
        state_r == dcs_pkg::DCS_OFFER && !slot_r[0] |->
            entry_w == u_table.mem_r[slot_r[SW-1:1]][7:0])
        else $error("even slot not from lower byte");
endmodule

// ===== design/dcs_table.sv
// schedule table storage: 128 halfword registers, write only from the bus
`include "dcs_map.svh"
module dcs_table #(
    parameter int WORDS = `DCS_TABLE_WORDS
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic wr_en,
    input wire logic [$clog2(WORDS*2)-1:0] wr_idx,
    input wire logic [15:0] wr_data,
    input wire logic [$clog2(WORDS*4)-1:0] rd_slot,
    output logic [7:0] rd_entry
);
    localparam int HW = WORDS * 2;
    // halfword array; index k holds the low halfword of bus word k
    logic [15:0] mem_r [HW];
    // selected halfword and byte for the requested slot
    wire [15:0] half_w = mem_r[rd_slot[$clog2(WORDS*4)-1:1]];

    genvar g;
    generate
        for (g = 0; g < HW; g++)
        begin : g_half
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    mem_r[g] <= `DCS_TABLE_RST;
                else if (wr_en && wr_idx == g)
                    mem_r[g] <= wr_data;
            end
        end
    endgenerate

    assign rd_entry = rd_slot[0] ? half_w[15:8] : half_w[7:0];
endmodule

// ===== inc/dcs_map.svh
// register offsets, field positions and reset values of the credit scheduler
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH
`define DCS_OFS_LAST 12'h000
`define DCS_OFS_ENABLE 12'h004
`define DCS_OFS_TABLE 12'h100
`define DCS_TABLE_WORDS 64
`define DCS_LAST_LSB 0
`define DCS_LAST_W 8
`define DCS_ENABLE_BIT 15
`define DCS_DIR_BIT 7
`define DCS_CHAN_LSB 0
`define DCS_CHAN_W 4
`define DCS_LAST_RST 8'h00
`define DCS_TABLE_RST 16'h0000
`endif

// ===== inc/dcs_pkg.sv
// types shared by the credit scheduler files
package dcs_pkg;
    // direction carried by a table entry
    typedef enum logic {
        DCS_DIR_TX = 1'b0,
        DCS_DIR_RX = 1'b1
    } dcs_dir_t;
    // scheduler walk states
    typedef enum logic [1:0] {
        DCS_IDLE,
        DCS_FETCH,
        DCS_OFFER
    } dcs_state_t;
endpackage
